// >>> bench/nvs_mst.sv
`timescale 1ns/100ps
`include "nvs_defs.vh"
module nvs_mst (
    input wire clk,
    input wire hready_reg,
    input wire [31:0] hrdata_reg,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata
);
    logic [31:0] rd_q [$];
    logic [31:0] mem [logic [31:0]];
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
    end
    // n pipelined transfers, then idle; lows counts wait cycles
    task automatic burst(input logic s, w, input logic [31:0] a,
        input int n, output int lows);
        lows = 0;
        for (int i = 0; i <= n; i++) begin
            @(negedge clk);
            hsel = s & (i < n);
            htrans = i == n ? 2'h0 : i == 0 ? 2'h2 : `NVS_TRANS_SEQ;
            haddr = a + 32'(4 * i);
            hwrite = w;
            // write word only in its data phase
            hwdata = (w && i > 0) ? {~haddr[15:0], haddr[15:0]} : ~hwdata;
            if (w && i > 0 && s)
                mem[haddr - 32'h4] = hwdata;
            // hold everything until ready is seen high mid-cycle
            while (hready_reg !== 1'b1 && lows < 20) begin
                lows++;
                @(negedge clk);
            end
            if (!w && i > 0)
                rd_q.push_back(hrdata_reg);
            @(posedge clk);
        end
        if (w)
            repeat (10) begin
                @(negedge clk);
                lows += int'(hready_reg === 1'b0);
            end
    endtask
    // one write word, then a read of that word right behind it
    task automatic wr_rd(input logic [31:0] a, output int lows,
        output logic [31:0] d);
        lows = 0;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            hsel = i < 2;
            htrans = i < 2 ? 2'h2 : 2'h0;
            haddr = a;
            hwrite = i == 0;
            // write word only in its data phase
            hwdata = i == 1 ? ~a : hwdata;
            while (hready_reg !== 1'b1 && lows < 20) begin
                lows++;
                @(negedge clk);
            end
            if (i == 2)
                d = hrdata_reg;
            @(posedge clk);
        end
    endtask
endmodule

// >>> bench/nvs_slave_bench.sv
`timescale 1ns/100ps
module nvs_slave_bench;
    logic clk, nrst;
    wire hsel, hwrite, hready_reg;
    wire [31:0] haddr, hwdata, hrdata_reg;
    wire [1:0] htrans;
    int err_count, n_tests, l;
    nvs_slave dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
        .hready_reg(hready_reg), .hrdata_reg(hrdata_reg));
    nvs_mst m (.clk(clk), .hready_reg(hready_reg), .hrdata_reg(hrdata_reg),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hwdata(hwdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task cmp(input string nm, input logic [31:0] e, s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task finish_test;
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task t_write;
        for (int k = 1; k <= 8; k++) begin
            m.burst(1, 1, 32'(k << 5), k, l);
            cmp("write wait", 32'(9 - k), l);
        end
        m.burst(1, 1, 32'h2f8, 3, l);
        cmp("cross write wait", 32'hf, l);
        m.burst(1, 0, 32'h300, 1, l);
        cmp("cross write data", m.mem[32'h300], m.rd_q.pop_front());
    endtask
    task t_wrrd;
        logic [31:0] d;
        m.wr_rd(32'h400, l, d);
        cmp("write-read wait", 32'hc, l);
        cmp("write-read data", 32'hfffffbff, d);
    endtask
    task t_rand;
        logic [31:0] a;
        for (int k = 1; k <= 8; k++) begin
            a = 32'((k << 5) + 4 * (k - 1));
            m.burst(1, 0, a, 1, l);
            cmp("read wait", 4, l);
            cmp("read data", m.mem[a], m.rd_q.pop_front());
        end
    endtask
    task t_seq;
        m.burst(1, 0, 32'h100, 8, l);
        cmp("seq wait", 4, l);
        for (int k = 0; k < 8; k++)
            cmp("seq data", m.mem[32'h100 + 4 * k], m.rd_q.pop_front());
        m.burst(1, 0, 32'hf8, 3, l);
        cmp("cross wait", 8, l);
        cmp("cross data", m.mem[32'hf8], m.rd_q.pop_front());
        void'(m.rd_q.pop_front());
        cmp("cross data", m.mem[32'h100], m.rd_q.pop_front());
    endtask
    task t_sel;
        m.burst(0, 0, 32'h20, 2, l);
        cmp("unselected wait", 0, l);
        m.rd_q.delete();
    endtask
    task t_rst;
        fork
            m.burst(1, 1, 32'h200, 2, l);
            begin
                repeat (4) @(negedge clk);
                nrst = 1'b0;
                #1 cmp("reset ready", 1, hready_reg);
                cmp("reset data", 0, hrdata_reg);
                @(negedge clk) nrst = 1'b1;
            end
        join
    endtask
    initial begin
        nrst = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (3) @(negedge clk);
        cmp("reset ready", 1, hready_reg);
        cmp("reset data", 0, hrdata_reg);
        nrst = 1'b1;
        t_write;
        t_rand;
        t_seq;
        t_sel;
        t_rst;
        t_wrrd;
        finish_test;
    end
    // the whole sequence needs well under 1000 cycles
    initial begin
        #20000;
        err_count++;
        finish_test;
    end
endmodule

// >>> bench/nvs_slave_chk.sv
`timescale 1ns/100ps
`include "nvs_defs.vh"
module nvs_chk (
    input wire clk,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready_reg,
    input wire [31:0] hrdata_reg
);
    reg dwr_reg, drd_reg;
    reg [17:0] a_reg;
    reg [3:0] n_reg, wl_reg;
    wire tk = hready_reg & hsel & htrans[1];
    wire nxt = haddr[19:2] == a_reg + 18'h1 && haddr[4:2] != 3'h0;
    wire sq = htrans == `NVS_TRANS_SEQ && nxt;
    wire cont = dwr_reg & tk & hwrite & sq;
    wire close = hready_reg & dwr_reg & !cont;
    // data phase kinds, group size and remaining group wait
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dwr_reg <= 1'b0;
            drd_reg <= 1'b0;
            a_reg <= 18'h0;
            n_reg <= 4'h0;
            wl_reg <= 4'h0;
        end else begin
            if (hready_reg) begin
                dwr_reg <= tk & hwrite;
                drd_reg <= tk & !hwrite;
            end
            if (tk)
                a_reg <= haddr[19:2];
            if (tk & hwrite)
                n_reg <= cont ? n_reg + 4'h1 : 4'h1;
            if (close)
                wl_reg <= `NVS_WR_WAIT_BASE - n_reg;
            else if (wl_reg != 4'h0)
                wl_reg <= wl_reg - 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence rd_wait;
        !hready_reg [*4] ##1 hready_reg;
    endsequence
    grp_wait_a: assert property (wl_reg != 4'h0 |-> !hready_reg)
        else $error("write group wait cut short");
    grp_end_a: assert property (wl_reg == 4'h1 && !drd_reg |=> hready_reg)
        else $error("write group wait too long");
    wr_gather_a: assert property (tk & hwrite & !close |=> hready_reg)
        else $error("wait while gathering writes");
    rd_rand_a: assert property (tk & !hwrite & !dwr_reg & !(drd_reg & sq)
        |=> rd_wait) else $error("random read wait wrong");
    wr_rd_wait_a: assert property (wl_reg == 4'h1 && drd_reg
        |=> rd_wait) else $error("read after write group wait wrong");
    rd_seq_a: assert property (tk & !hwrite & drd_reg & sq |=> hready_reg)
        else $error("sequential read stalled");
    rd_hold_a: assert property ($changed(hrdata_reg) |-> $past(drd_reg))
        else $error("read data changed outside read");
    rst_idle_a: assert property ($rose(nrst) |-> hready_reg
        && hrdata_reg == 32'h0) else $error("not idle after reset");
    sel_ignore_a: assert property (hready_reg & !hsel & !dwr_reg
        |=> hready_reg) else $error("unselected cycle stalled");
endmodule
bind nvs_slave nvs_chk chk (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready_reg(hready_reg), .hrdata_reg(hrdata_reg));

// >>> design/nvs_slave.v
// Overview of operation
// [R1] storage array built as eight equal planes
// [R2] access moves 256-bit line, address picks word
// [R3] sequential read: four waits, then one per clock
// [R4] each random read waits four cycles; one right behind a write group waits the group's 9-N cycles first
// [R5] full eight-word write group waits one cycle
// [R6] write group of N words waits 9-N
// [R7] address phase stretched only by previous transfer
// [R8] hready low per wait, high at completion
// [R9] hwrite high writes hwdata, low reads hrdata
// [R10] address and control captured ending address phase
// [R11] master drives write data in data phase
// [R12] read holds hready low until word valid
// [R13] master keeps hwrite fixed through a burst
// [R14] reset returns to standby, drops transfer
// [R15] only selected transfers are answered
// [R16] group closes on break, read, idle, line
// [R17] sequential read means next word same line
`timescale 1ns/100ps
`include "nvs_defs.vh"

module nvs_slave (
    input wire clk,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    output reg hready_reg,
    output reg [31:0] hrdata_reg
);

////////////////////////////////////////////////////////////////////////////
reg [1:0] state_reg;
reg [3:0] cnt_reg;
reg dp_write_reg;
reg [31:0] dp_addr_reg;
reg [3:0] grp_cnt_reg;
reg [`NVS_LINE_AW-1:0] grp_line_reg;
reg [`NVS_PLANES-1:0] grp_mask_reg;
reg [`NVS_LINE_W-1:0] grp_data_reg;
reg [`NVS_LINE_W-1:0] lbuf_reg;
reg [`NVS_LINE_AW-1:0] lbuf_line_reg;
reg lbuf_valid_reg;
reg [2:0] last_word_reg;
reg [31:0] rd_addr_reg;
reg pend_acc_reg;
reg pend_wr_reg;
reg pend_seq_reg;
reg [31:0] pend_addr_reg;
reg commit_reg;
reg [`NVS_LINE_AW-1:0] commit_line_reg;
reg [`NVS_PLANES-1:0] commit_mask_reg;
reg [`NVS_LINE_W-1:0] commit_data_reg;

wire [`NVS_LINE_W-1:0] plane_rd;
wire [`NVS_LINE_AW-1:0] rd_line;
assign rd_line = rd_addr_reg[`NVS_LINE_MSB:`NVS_LINE_LSB];

////////////////////////////////////////////////////////////////////////////
// [R1] eight planes, each one word of every line
genvar p;
generate
    for (p = 0; p < `NVS_PLANES; p = p + 1) begin : g_plane
        reg [`NVS_WORD_W-1:0] mem [0:`NVS_LINES-1];
        always @(posedge clk) begin
            if (commit_reg && commit_mask_reg[p]) begin
                mem[commit_line_reg] <= commit_data_reg[p*32 +: 32];
            end
        end
        assign plane_rd[p*32 +: 32] = mem[rd_line];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// gather path: word arriving in this write data phase
wire store;
reg [`NVS_PLANES-1:0] g_mask_next;
reg [`NVS_LINE_W-1:0] g_data_next;
reg [3:0] n_next;
assign store = hready_reg & dp_write_reg;

always @* begin
    g_mask_next = grp_mask_reg;
    g_data_next = grp_data_reg;
    n_next = grp_cnt_reg;
    // [R11] write word taken in data phase
    if (store) begin
        g_mask_next[dp_addr_reg[4:2]] = 1'b1;
        g_data_next[dp_addr_reg[4:2]*32 +: 32] = hwdata;
        n_next = grp_cnt_reg + 4'h1;
    end
end

// [R15] only selected, non-idle transfers count
wire bus_acc;
wire bus_seq;
wire [2:0] dp_word_inc;
wire wcont;
wire close;
assign bus_acc = hsel & htrans[1];
assign bus_seq = htrans == `NVS_TRANS_SEQ;
assign dp_word_inc = dp_addr_reg[4:2] + 3'h1;
// [R16] group continues only on next word, same line
assign wcont = bus_acc & hwrite & bus_seq & (n_next < 4'h8) &
    (haddr[`NVS_LINE_MSB:`NVS_LINE_LSB] == grp_line_reg) &
    (haddr[4:2] == dp_word_inc);
assign close = hready_reg & (n_next != 4'h0) & ~wcont;

////////////////////////////////////////////////////////////////////////////
// transfer start source: live bus or the one held during commit wait
wire from_pend;
wire s_acc;
wire s_wr;
wire s_seq;
wire [31:0] s_addr;
wire s_hit;
wire [2:0] last_inc;
assign from_pend = state_reg == `NVS_ST_WWAIT;
assign s_acc = from_pend ? pend_acc_reg : bus_acc;
assign s_wr = from_pend ? pend_wr_reg : hwrite;
assign s_seq = from_pend ? pend_seq_reg : bus_seq;
assign s_addr = from_pend ? pend_addr_reg : haddr;
assign last_inc = last_word_reg + 3'h1;
// [R17] sequential hit: next word in buffered line
assign s_hit = s_seq & lbuf_valid_reg &
    (s_addr[`NVS_LINE_MSB:`NVS_LINE_LSB] == lbuf_line_reg) &
    (s_addr[4:2] == last_inc);

////////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge nrst) begin
    // [R14] reset abandons everything to standby
    if (!nrst) begin
        state_reg <= `NVS_ST_IDLE;
        cnt_reg <= 4'h0;
        hready_reg <= 1'b1;
        hrdata_reg <= 32'h0;
        dp_write_reg <= 1'b0;
        dp_addr_reg <= 32'h0;
        grp_cnt_reg <= 4'h0;
        grp_line_reg <= {`NVS_LINE_AW{1'b0}};
        grp_mask_reg <= 8'h0;
        grp_data_reg <= {`NVS_LINE_W{1'b0}};
        lbuf_reg <= {`NVS_LINE_W{1'b0}};
        lbuf_line_reg <= {`NVS_LINE_AW{1'b0}};
        lbuf_valid_reg <= 1'b0;
        last_word_reg <= 3'h0;
        rd_addr_reg <= 32'h0;
        pend_acc_reg <= 1'b0;
        pend_wr_reg <= 1'b0;
        pend_seq_reg <= 1'b0;
        pend_addr_reg <= 32'h0;
        commit_reg <= 1'b0;
        commit_line_reg <= {`NVS_LINE_AW{1'b0}};
        commit_mask_reg <= 8'h0;
        commit_data_reg <= {`NVS_LINE_W{1'b0}};
    end else begin
        commit_reg <= 1'b0;
        case (state_reg)
        `NVS_ST_IDLE: begin
            if (close) begin
                // [R5] commit gathered line, wait 9-N cycles
                commit_reg <= 1'b1;
                commit_line_reg <= grp_line_reg;
                commit_mask_reg <= g_mask_next;
                commit_data_reg <= g_data_next;
                if (lbuf_line_reg == grp_line_reg) begin
                    lbuf_valid_reg <= 1'b0;
                end
                grp_cnt_reg <= 4'h0;
                grp_mask_reg <= 8'h0;
                // [R6] wait shrinks as the group grows
                cnt_reg <= `NVS_WR_WAIT_BASE - n_next;
                hready_reg <= 1'b0;
                state_reg <= `NVS_ST_WWAIT;
                dp_write_reg <= 1'b0;
                // [R7] next address phase held over the wait
                pend_acc_reg <= bus_acc;
                pend_wr_reg <= hwrite;
                pend_seq_reg <= bus_seq;
                pend_addr_reg <= haddr;
            end else begin
                grp_cnt_reg <= n_next;
                grp_mask_reg <= g_mask_next;
                grp_data_reg <= g_data_next;
                dp_write_reg <= 1'b0;
                // [R10] control captured on edge ending address phase
                if (s_acc && s_wr) begin
                    // [R9] write data phase follows
                    dp_write_reg <= 1'b1;
                    dp_addr_reg <= s_addr;
                    grp_line_reg <= s_addr[`NVS_LINE_MSB:`NVS_LINE_LSB];
                end else if (s_acc && s_hit) begin
                    // [R3] streamed word, no wait
                    hrdata_reg <= lbuf_reg[s_addr[4:2]*32 +: 32];
                    last_word_reg <= s_addr[4:2];
                end else if (s_acc) begin
                    // [R4] random read wait
                    rd_addr_reg <= s_addr;
                    cnt_reg <= `NVS_RD_WAIT;
                    hready_reg <= 1'b0;
                    state_reg <= `NVS_ST_RWAIT;
                end
            end
        end
        `NVS_ST_WWAIT: begin
            if (cnt_reg == 4'h1) begin
                hready_reg <= 1'b1;
                state_reg <= `NVS_ST_IDLE;
                if (s_acc && s_wr) begin
                    dp_write_reg <= 1'b1;
                    dp_addr_reg <= s_addr;
                    grp_line_reg <= s_addr[`NVS_LINE_MSB:`NVS_LINE_LSB];
                end else if (s_acc && s_hit) begin
                    hrdata_reg <= lbuf_reg[s_addr[4:2]*32 +: 32];
                    last_word_reg <= s_addr[4:2];
                end else if (s_acc) begin
                    rd_addr_reg <= s_addr;
                    cnt_reg <= `NVS_RD_WAIT;
                    hready_reg <= 1'b0;
                    state_reg <= `NVS_ST_RWAIT;
                end
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
        `NVS_ST_RWAIT: begin
            // [R12] hold ready low until word valid
            if (cnt_reg == 4'h1) begin
                // [R2] whole line read, word picked by address
                lbuf_reg <= plane_rd;
                lbuf_line_reg <= rd_line;
                lbuf_valid_reg <= 1'b1;
                last_word_reg <= rd_addr_reg[4:2];
                hrdata_reg <= plane_rd[rd_addr_reg[4:2]*32 +: 32];
                // [R8] ready high in completing cycle
                hready_reg <= 1'b1;
                state_reg <= `NVS_ST_IDLE;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
        default: begin
            state_reg <= `NVS_ST_IDLE;
            hready_reg <= 1'b1;
        end
        endcase
    end
end

endmodule

// >>> pkg/nvs_defs.vh
`ifndef NVS_DEFS_VH
`define NVS_DEFS_VH

// array shape: eight planes, one 32-bit word of a 256-bit line each
`define NVS_PLANES 8
`define NVS_LINE_W 256
`define NVS_WORD_W 32
`define NVS_LINES 32768
`define NVS_LINE_AW 15
`define NVS_LINE_LSB 5
`define NVS_LINE_MSB 19
`define NVS_WSEL_LSB 2
`define NVS_WSEL_MSB 4

// bus transfer types
`define NVS_TRANS_SEQ 2'h3

// wait cycles
`define NVS_RD_WAIT 4'h4
`define NVS_WR_WAIT_BASE 4'h9

// state codes
`define NVS_ST_IDLE 2'h0
`define NVS_ST_RWAIT 2'h1
`define NVS_ST_WWAIT 2'h2

`endif
